// >>> hdl/rfid_regs_defs.svh
// Register offsets, field positions, reset values and level codes for the
// reader front-end control and test registers.
// Assumes inclusion by bare name from files that need these values.
`ifndef RFID_REGS_DEFS_SVH
`define RFID_REGS_DEFS_SVH

`define ADDR_RX_ACTIVE 5'h11
`define ADDR_FIFO_WM 5'h14
`define ADDR_TEST_A 5'h1A
`define ADDR_TEST_B 5'h1B
`define REG_RESET 8'h00
`define WM_WRITE_MASK 8'h0F
`define TEST_B_WRITE_MASK 8'h4F
`define TEST_B_AUTO_CLEAR 8'h0E
`define RXACT_BIT 0
`define HI_SEL_MSB 3
`define HI_SEL_LSB 2
`define LO_SEL_MSB 1
`define LO_SEL_LSB 0
`define TA_KEY_IN 7
`define TA_SUBC_OUT 6
`define TA_DIRECT 5
`define TA_STAGE_SEL 4
`define TA_CUT2 3
`define TA_CUT1 2
`define TA_FOLLOW 1
`define TA_AGC 0
`define TB_RF_LEVEL 6
`define TB_IO1 3
`define TB_IO0 2
`define TB_DEC 1
`define TB_FAST 0
`define HI_LVL_0 7'd124
`define HI_LVL_1 7'd120
`define HI_LVL_2 7'd112
`define HI_LVL_3 7'd96
`define LO_LVL_0 7'd4
`define LO_LVL_1 7'd8
`define LO_LVL_2 7'd16
`define LO_LVL_3 7'd32
`define FIFO_MAX 8'd127

`endif

// >>> hdl/rfid_regs_pkg.sv
// Types shared by the control and test register bank.
// Assumes the defines header is compiled alongside.
package rfid_regs_pkg;
   typedef enum logic [1:0] {phase_idle, phase_rx, phase_tx} link_phase_t;
endpackage : rfid_regs_pkg

// >>> hdl/fifo_level_watch.sv
// FIFO fill-level watcher: watermark compare and overflow flag.
// Assumes byte count and push strobe come from logic on ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "rfid_regs_defs.svh"
module fifo_level_watch
   import rfid_regs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clear,
   input wire link_phase_t phase,
   input wire logic [1:0] hi_sel,
   input wire logic [1:0] lo_sel,
   input wire logic [6:0] byte_count,
   input wire logic push,
   output logic level_irq,
   output logic overflow
);
   typedef struct packed {
      logic irq;
      logic ovf;
   } watch_state_t;

   watch_state_t st;
   watch_state_t next_st;

   // High watermark code to byte level
   function automatic logic [6:0] hi_level(input logic [1:0] code);
      unique case (code)
         2'h0: hi_level = `HI_LVL_0;
         2'h1: hi_level = `HI_LVL_1;
         2'h2: hi_level = `HI_LVL_2;
         2'h3: hi_level = `HI_LVL_3;
      endcase
   endfunction : hi_level

   // Low watermark code to byte level
   function automatic logic [6:0] lo_level(input logic [1:0] code);
      unique case (code)
         2'h0: lo_level = `LO_LVL_0;
         2'h1: lo_level = `LO_LVL_1;
         2'h2: lo_level = `LO_LVL_2;
         2'h3: lo_level = `LO_LVL_3;
      endcase
   endfunction : lo_level

   // Level compare per direction; overflow sticky until clear
   always_comb begin
      next_st = st;
      next_st.irq = 1'b0;
      if (phase == phase_rx && byte_count >= hi_level(hi_sel)) begin
         next_st.irq = 1'b1;
      end
      if (phase == phase_tx && byte_count <= lo_level(lo_sel)) begin
         next_st.irq = 1'b1;
      end
      if (clear) begin
         next_st.ovf = 1'b0;
      end
      if (push && {1'b0, byte_count} >= `FIFO_MAX) begin
         next_st.ovf = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_irq = st.irq;
   assign overflow = st.ovf;
endmodule : fifo_level_watch
`default_nettype wire

// >>> hdl/rfid_ctrl_regs.sv
// Control and test register bank of the reader front end: receive-active
// mirror, FIFO watermarks, test/direct-use registers and their pin effects.
// Assumes a simple synchronous register port on ref_clk from the host
// interface, and raw pins (enable, keying, depth) from outside the domain.
//
// Operation
// - Bit 0 at 0x11 mirrors the receive-start flag of interrupt status.
// - Mirror sets on receive start-of-frame, stays set while reception runs.
// - Interrupt request pulses when a flagged reception completes.
// - Register 0x14 sets FIFO levels reported through interrupt request.
// - Receive high level codes 00..11 give 124, 120, 112, 96 bytes.
// - Transmit low level codes 00..11 give 4, 8, 16, 32 bytes.
// - Watermark and test registers clear on power-on reset and enable low.
// - Test A bit 7 routes keying pin into receive decoder.
// - Test A bit 6 drives digitized subcarrier out on depth pin.
// - Test A bit 5 makes depth pin an input controlling modulation.
// - Test A bit 4 picks first or second stage for analog out.
// - Test A bits 3,2 cut second/first stage gain and corner.
// - Test A bit 0 shows gain control level on main strength bits.
// - Decoder or I/O test bit in test B enters test mode.
// - Test mode holds until the host interface signals stop or enable goes low.
// - Stop clears decoder and both I/O test bits automatically.
// - Test B bit 0 clocks transmit coders at full reference rate.
// - FIFO holds 127 bytes; overflow flagged; count in seven bits.
`timescale 1ns/1ns
`default_nettype none
`include "rfid_regs_defs.svh"
module rfid_ctrl_regs
   import rfid_regs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chip_enable,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic host_stop,
   input wire logic rx_sof,
   input wire logic rx_done,
   input wire logic tx_active,
   input wire logic [6:0] fifo_count,
   input wire logic fifo_push,
   input wire logic keying_pin_in,
   input wire logic keying_depth_pin_in,
   input wire logic rx_subcarrier,
   input wire logic internal_modulation,
   input wire logic internal_decoder_in,
   input wire logic [2:0] rssi_measured,
   input wire logic [2:0] agc_level,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic irq,
   output logic rx_active,
   output logic fifo_overflow,
   output logic keying_depth_pin_out,
   output logic keying_depth_pin_oe,
   output logic decoder_data_in,
   output logic tx_modulation,
   output logic second_stage_select,
   output logic second_stage_gain_cut,
   output logic first_stage_gain_cut,
   output logic follower_test,
   output logic [2:0] rssi_main,
   output logic field_level_test,
   output logic test_mode,
   output logic coder_fast_clock
);
   typedef struct packed {
      logic [1:0] en_sync;
      logic [1:0] key_sync;
      logic [1:0] depth_sync;
      logic [7:0] wm;
      logic [7:0] test_a;
      logic [7:0] test_b;
      logic rx_act;
      logic tmode;
      logic irq;
      logic [7:0] rdata;
      logic rvalid;
      logic depth_out;
      logic depth_oe;
      logic dec_in;
      logic tx_mod;
      logic [2:0] rssi;
   } regs_state_t;

   regs_state_t st;
   regs_state_t next_st;
   link_phase_t phase;
   logic level_irq;
   logic ovf;
   logic en_low;

   // Direction of the link decides which watermark applies
   always_comb begin
      if (st.rx_act) begin
         phase = phase_rx;
      end else if (tx_active) begin
         phase = phase_tx;
      end else begin
         phase = phase_idle;
      end
   end

   // Enable pin low (second sync stage) holds watermark and test registers at reset value
   assign en_low = ~st.en_sync[1];

   fifo_level_watch u_watch (
      .ref_clk(ref_clk),
      .rst(rst),
      .clear(en_low),
      .phase(phase),
      .hi_sel(st.wm[`HI_SEL_MSB:`HI_SEL_LSB]),
      .lo_sel(st.wm[`LO_SEL_MSB:`LO_SEL_LSB]),
      .byte_count(fifo_count),
      .push(fifo_push),
      .level_irq(level_irq),
      .overflow(ovf)
   );

   // Register writes, test-mode tracking, pin routing and read data
   always_comb begin
      next_st = st;
      next_st.en_sync = {st.en_sync[0], chip_enable};
      next_st.key_sync = {st.key_sync[0], keying_pin_in};
      next_st.depth_sync = {st.depth_sync[0], keying_depth_pin_in};
      // Receive-active mirror: set on SOF wins over completion
      if (rx_done) begin
         next_st.rx_act = 1'b0;
      end
      if (rx_sof) begin
         next_st.rx_act = 1'b1;
      end
      next_st.irq = (st.rx_act & rx_done) | level_irq;
      // Host writes; read-only mirror and reserved bits ignored
      if (reg_wr) begin
         unique case (reg_addr)
            `ADDR_FIFO_WM: next_st.wm = reg_wdata & `WM_WRITE_MASK;
            `ADDR_TEST_A: next_st.test_a = reg_wdata;
            `ADDR_TEST_B: next_st.test_b = reg_wdata & `TEST_B_WRITE_MASK;
            default: ;
         endcase
      end
      // Test bits enter test mode until stop clears them
      if ((next_st.test_b & `TEST_B_AUTO_CLEAR) != 8'h00) begin
         next_st.tmode = 1'b1;
      end
      if (host_stop) begin
         next_st.test_b = next_st.test_b & ~`TEST_B_AUTO_CLEAR;
         next_st.tmode = 1'b0;
      end
      if (en_low) begin
         next_st.wm = `REG_RESET;
         next_st.test_a = `REG_RESET;
         next_st.test_b = `REG_RESET;
         next_st.tmode = 1'b0;
      end
      // Depth pin: output for subcarrier, input under direct keying
      next_st.depth_oe = st.test_a[`TA_SUBC_OUT] & ~st.test_a[`TA_DIRECT];
      next_st.depth_out = rx_subcarrier;
      next_st.tx_mod = st.test_a[`TA_DIRECT] ? st.depth_sync[1] : internal_modulation;
      next_st.dec_in = st.test_a[`TA_KEY_IN] ? st.key_sync[1] : internal_decoder_in;
      next_st.rssi = st.test_a[`TA_AGC] ? agc_level : rssi_measured;
      // Read port: one-cycle valid, unmapped reads zero
      next_st.rvalid = reg_rd;
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `ADDR_RX_ACTIVE: next_st.rdata = {7'h00, st.rx_act};
            `ADDR_FIFO_WM: next_st.rdata = st.wm;
            `ADDR_TEST_A: next_st.rdata = st.test_a;
            `ADDR_TEST_B: next_st.rdata = st.test_b;
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flip-flops
   assign reg_rdata = st.rdata;
   assign reg_rvalid = st.rvalid;
   assign irq = st.irq;
   assign rx_active = st.rx_act;
   assign fifo_overflow = ovf;
   assign keying_depth_pin_out = st.depth_out;
   assign keying_depth_pin_oe = st.depth_oe;
   assign decoder_data_in = st.dec_in;
   assign tx_modulation = st.tx_mod;
   assign second_stage_select = st.test_a[`TA_STAGE_SEL];
   assign second_stage_gain_cut = st.test_a[`TA_CUT2];
   assign first_stage_gain_cut = st.test_a[`TA_CUT1];
   assign follower_test = st.test_a[`TA_FOLLOW];
   assign rssi_main = st.rssi;
   assign field_level_test = st.test_b[`TB_RF_LEVEL];
   assign test_mode = st.tmode;
   assign coder_fast_clock = st.test_b[`TB_FAST];
endmodule : rfid_ctrl_regs
`default_nettype wire

// >>> testbench/rfid_ctrl_regs_properties.sv
// Timing checks on the control and test register bank.
// Assumes it is bound onto rfid_ctrl_regs and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module rfid_ctrl_regs_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chip_enable,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic host_stop,
   input wire logic rx_sof,
   input wire logic rx_done,
   input wire logic [6:0] fifo_count,
   input wire logic fifo_push,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic irq,
   input wire logic rx_active,
   input wire logic fifo_overflow,
   input wire logic test_mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Read answered one cycle after it is taken
   property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_mirror; reg_rd && reg_addr == 5'h11 |=> reg_rdata == {7'h00, $past(rx_active)}; endproperty
   a_mirror: assert property (p_mirror) else $error("bad mirror read");
   // Receive flag sets on start and holds until done
   property p_sof; rx_sof |=> rx_active; endproperty
   a_sof: assert property (p_sof) else $error("flag not set");
   property p_hold; rx_active && !rx_done |=> rx_active; endproperty
   a_hold: assert property (p_hold) else $error("flag dropped early");
   property p_irq; rx_active && rx_done && !rx_sof |=> irq; endproperty
   a_irq: assert property (p_irq) else $error("no completion irq");
   // Test mode lasts until stop while enable is high, stop ends it
   property p_stay; test_mode && !host_stop && chip_enable |=> test_mode; endproperty
   a_stay: assert property (p_stay) else $error("test mode lost");
   property p_stop; host_stop |=> !test_mode; endproperty
   a_stop: assert property (p_stop) else $error("test mode kept");
   property p_ovf; fifo_push && fifo_count == 7'd127 && chip_enable |=> fifo_overflow; endproperty
   a_ovf: assert property (p_ovf) else $error("no overflow");
endmodule : rfid_ctrl_regs_checker

bind rfid_ctrl_regs rfid_ctrl_regs_checker i_chk (.ref_clk, .rst, .chip_enable, .reg_rd,
   .reg_addr, .host_stop, .rx_sof, .rx_done, .fifo_count, .fifo_push, .reg_rdata,
   .reg_rvalid, .irq, .rx_active, .fifo_overflow, .test_mode);
`default_nettype wire

// >>> testbench/host_port_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes requests are taken at ref_clk rising edges.
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [4:0] reg_addr = 5'h00,
   output logic [7:0] reg_wdata = 8'h00
);
   // Write held over one rising edge; stale data inverted after
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   // Read; answer is taken in the cycle after the read edge
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : host_port_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the control and test register bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic ref_clk, reg_wr, reg_rd, reg_rvalid, irq, rx_active, fifo_overflow, test_mode;
   logic rst = 1'b1, chip_enable = 1'b1, host_stop = 1'b0, rx_sof = 1'b0, rx_done = 1'b0;
   logic tx_active = 1'b0, fifo_push = 1'b0, keying_pin_in = 1'b1, keying_depth_pin_in = 1'b1;
   logic rx_subcarrier = 1'b1, internal_modulation = 1'b1, internal_decoder_in = 1'b1;
   logic [2:0] rssi_measured = 3'h1, agc_level = 3'h6, rssi_main;
   logic [6:0] fifo_count = 7'h00;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic keying_depth_pin_out, keying_depth_pin_oe, decoder_data_in, tx_modulation;
   logic second_stage_select, second_stage_gain_cut, first_stage_gain_cut, follower_test;
   logic field_level_test, coder_fast_clock;
   int n_fail = 0, cmp_count = 0, cycles = 0;

   rfid_ctrl_regs i_dut (.ref_clk, .rst, .chip_enable, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .host_stop, .rx_sof, .rx_done, .tx_active, .fifo_count, .fifo_push,
      .keying_pin_in, .keying_depth_pin_in, .rx_subcarrier, .internal_modulation,
      .internal_decoder_in, .rssi_measured, .agc_level, .reg_rdata, .reg_rvalid, .irq,
      .rx_active, .fifo_overflow, .keying_depth_pin_out, .keying_depth_pin_oe,
      .decoder_data_in, .tx_modulation, .second_stage_select, .second_stage_gain_cut,
      .first_stage_gain_cut, .follower_test, .rssi_main, .field_level_test, .test_mode,
      .coder_fast_clock);
   host_port_model i_host (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

   // Clock and run-length limit
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse(ref logic s);
      @(negedge ref_clk);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
   endtask : pulse
   task automatic lvl(input logic [6:0] c, input logic e);
      fifo_count = c;
      repeat (3) @(negedge ref_clk);
      chk(irq, e);
   endtask : lvl

   // Defaults, unmapped space, reserved bits
   task automatic t_regs();
      for (int a = 0; a < 4; a++) begin
         i_host.rd(a == 0 ? 5'h14 : a == 1 ? 5'h1A : a == 2 ? 5'h1B : 5'h05, d);
         chk(d, 8'h00);
      end
      i_host.wr(5'h14, 8'hFF);
      i_host.rd(5'h14, d);
      chk(d, 8'h0F);
   endtask : t_regs

   // Receive mirror and every watermark code in both phases
   task automatic t_wm();
      logic [6:0] hi [4] = '{7'd124, 7'd120, 7'd112, 7'd96};
      logic [6:0] lo [4] = '{7'd4, 7'd8, 7'd16, 7'd32};
      pulse(rx_sof);
      i_host.wr(5'h11, 8'h00);
      i_host.rd(5'h11, d);
      chk(d, 8'h01);
      for (int i = 0; i < 4; i++) begin
         i_host.wr(5'h14, {4'h0, 2'(i), 2'(i)});
         lvl(hi[i] - 7'd1, 1'b0);
         lvl(hi[i], 1'b1);
      end
      pulse(rx_done);
      i_host.rd(5'h11, d);
      chk(d, 8'h00);
      tx_active = 1'b1;
      for (int i = 0; i < 4; i++) begin
         i_host.wr(5'h14, {4'h0, 2'(i), 2'(i)});
         lvl(lo[i] + 7'd1, 1'b0);
         lvl(lo[i], 1'b1);
      end
      tx_active = 1'b0;
   endtask : t_wm

   // Analog and pin routing from the first test register
   task automatic t_test_a();
      i_host.wr(5'h1A, 8'h17);
      chk({second_stage_select, second_stage_gain_cut, first_stage_gain_cut}, 8'h05);
      // Strength mux registers one cycle after the register bit
      @(negedge ref_clk);
      chk({follower_test, rssi_main}, 8'h0E);
      i_host.wr(5'h1A, 8'h40);
      rx_subcarrier = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({keying_depth_pin_oe, keying_depth_pin_out, rssi_main}, 8'h11);
      i_host.wr(5'h1A, 8'h60);
      keying_depth_pin_in = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({keying_depth_pin_oe, tx_modulation}, 8'h00);
      i_host.wr(5'h1A, 8'h80);
      keying_pin_in = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk(decoder_data_in, 8'h00);
   endtask : t_test_a

   // Test mode entry, persistence and stop in the second test register
   task automatic t_test_b();
      for (int i = 1; i < 4; i++) begin
         i_host.wr(5'h1B, 8'h01 << i);
         repeat (5) @(negedge ref_clk);
         chk(test_mode, 8'h01);
         pulse(host_stop);
         chk(test_mode, 8'h00);
      end
      i_host.wr(5'h1B, 8'hFF);
      chk({field_level_test, coder_fast_clock}, 8'h03);
      pulse(host_stop);
      i_host.rd(5'h1B, d);
      chk(d, 8'h41);
   endtask : t_test_b

   // Overflow, then enable low clears overflow and the watermark and test registers
   task automatic t_en();
      fifo_count = 7'd127;
      pulse(fifo_push);
      @(negedge ref_clk);
      chk(fifo_overflow, 8'h01);
      chip_enable = 1'b0;
      repeat (5) @(negedge ref_clk);
      chip_enable = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(fifo_overflow, 8'h00);
      for (int a = 0; a < 3; a++) begin
         i_host.rd(a == 0 ? 5'h14 : a == 1 ? 5'h1A : 5'h1B, d);
         chk(d, 8'h00);
      end
   endtask : t_en

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      t_regs();
      t_wm();
      t_test_a();
      t_test_b();
      t_en();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
